// [common/bbxc_pkg.sv]
package bbxc_pkg;
    // ---------------------------------------------------------------
    // Opcodes
    // ---------------------------------------------------------------
    localparam logic [7:0] OPC_BIT_JUMP = 8'h37;
    localparam logic [7:0] OPC_BIT_XOR = 8'h27;
    localparam logic [7:0] OPC_CALL_DIRECT = 8'hF6;
    localparam logic [7:0] OPC_CALL_PAIR = 8'hF4;
    localparam logic [7:0] OPC_CALL_VECTOR = 8'hD4;
    // ---------------------------------------------------------------
    // Instruction lengths and cycle counts
    // ---------------------------------------------------------------
    localparam logic [15:0] LEN_THREE = 16'h0003;
    localparam logic [15:0] LEN_TWO = 16'h0002;
    localparam logic [3:0] CYC_BIT_JUMP = 4'hA;
    localparam logic [3:0] CYC_BIT_XOR = 4'h6;
    localparam logic [3:0] CYC_CALL_DIRECT = 4'hE;
    localparam logic [3:0] CYC_CALL_PAIR = 4'hC;
    localparam logic [3:0] CYC_CALL_VECTOR = 4'hE;
    localparam logic [3:0] CYC_ONE = 4'h1;
    // ---------------------------------------------------------------
    // Second byte fields
    // ---------------------------------------------------------------
    localparam int B2_REG_HI = 7;
    localparam int B2_REG_LO = 4;
    localparam int B2_BIT_HI = 3;
    localparam int B2_BIT_LO = 1;
    localparam int B2_SEL = 0;
    // ---------------------------------------------------------------
    // Flag bit positions
    // ---------------------------------------------------------------
    localparam int FLAG_Z = 6;
    localparam int FLAG_S = 5;
    // ---------------------------------------------------------------
    // Register map (byte addresses)
    // ---------------------------------------------------------------
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_FLAGS = 8'h04;
    localparam logic [7:0] REG_SP = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0C;
    localparam logic [7:0] REG_LAST_PC = 8'h10;
    localparam int CTRL_EN = 0;
    localparam int ST_BUSY = 0;
    localparam int ST_TAKEN = 1;
    localparam int ST_ILLEGAL = 2;
    localparam logic CTRL_RESET = 1'b1;
    localparam logic [7:0] FLAGS_RESET = 8'h00;
    localparam logic [15:0] SP_RESET = 16'h0000;
    localparam logic [3:0] WORK_BASE = 4'hC;
    // ---------------------------------------------------------------
    // Sequencer states, Gray coded in the order declared
    // ---------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_RD1 = 4'h1,
        ST_RD2 = 4'h3,
        ST_EXEC = 4'h2,
        ST_VEC1 = 4'h6,
        ST_VEC2 = 4'h7,
        ST_PUSH_LO = 4'h5,
        ST_PUSH_HI = 4'h4,
        ST_WAIT = 4'hC
    } bbxc_state_type;
endpackage

// [design/bbxc_exec.sv]
// Operation
// - Jump-if-bit-set tests source working register bit; set bit adds displacement to PC.
// - Opcode 37, three bytes, 10 cycles; second byte register, bit index, selector.
// - Displacement is signed, reaching 127 forward to 128 backward.
// - Bit jump and procedure call leave every status flag unchanged.
// - Bit exclusive-OR combines selected bit with bit zero of other operand.
// - Only the selected destination bit is written; source left untouched.
// - Zero flag reflects inverted result, sign cleared, other flags kept.
// - Opcode 27, three bytes, 6 cycles; selector picks the destination form.
// - Call pushes low PC byte then high byte, each after SP decrement.
// - Pushed PC is the address just after the whole call instruction.
// - Call forms F6 direct 3/14, F4 pair 2/12, D4 vector 2/14.
// - Vector call reads two program bytes, high first, into the PC.
// - Selector zero jumps when the tested bit is zero instead.
`timescale 1ns/1ps
`default_nettype none
module bbxc_exec
    import bbxc_pkg::*;
#(
    parameter logic [3:0] WORK_BASE_P = WORK_BASE
) (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic instr_valid_i,
    input wire logic [7:0] opcode_i,
    input wire logic [7:0] byte2_i,
    input wire logic [7:0] byte3_i,
    input wire logic [15:0] instr_pc_i,
    output logic busy_o,
    output logic done_o,
    output logic pc_load_o,
    output logic [15:0] pc_o,
    output logic [7:0] rf_addr_o,
    input wire logic [7:0] rf_rdata_i,
    output logic rf_we_o,
    output logic [7:0] rf_wdata_o,
    output logic [15:0] pm_addr_o,
    input wire logic [7:0] pm_rdata_i,
    output logic stk_we_o,
    output logic [15:0] stk_addr_o,
    output logic [7:0] stk_wdata_o,
    output logic [7:0] flags_o,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o
);
    // ---------------------------------------------------------------
    // Reset release
    // ---------------------------------------------------------------
    logic rst_s1_r;
    logic rst_n;

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_s1_r <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_n <= rst_s1_r;
        end
    end

    // ---------------------------------------------------------------
    // Declarations
    // ---------------------------------------------------------------
    bbxc_state_type state_r;
    logic [7:0] opc_r;
    logic [7:0] b2_r;
    logic [7:0] b3_r;
    logic [15:0] ret_r;
    logic [15:0] target_r;
    logic [7:0] opa_r;
    logic [3:0] cnt_r;
    logic taken_r;
    logic ctrl_en_r;
    logic illegal_r;
    logic [7:0] flags_r;
    logic [15:0] sp_r;
    logic [15:0] last_pc_r;
    logic wb_req;
    logic wb_wr;
    logic start;
    logic known_op;
    logic [3:0] cyc_nxt;
    logic [15:0] len_nxt;
    logic [2:0] bit_idx;
    logic sel_bit;
    logic [7:0] work_addr;
    logic xor_bit;
    logic [7:0] xor_word;
    logic xor_wr;
    logic finish;

    assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wb_wr = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0];
    assign start = instr_valid_i && (state_r == ST_IDLE) && ctrl_en_r;
    assign bit_idx = b2_r[B2_BIT_HI:B2_BIT_LO];
    assign sel_bit = b2_r[B2_SEL];
    assign work_addr = {WORK_BASE_P, b2_r[B2_REG_HI:B2_REG_LO]};
    assign finish = (state_r == ST_WAIT) && (cnt_r == 4'h0);

    // ---------------------------------------------------------------
    // Opcode decode
    // ---------------------------------------------------------------
    always_comb begin
        known_op = 1'b1;
        cyc_nxt = CYC_ONE;
        len_nxt = LEN_THREE;
        case (opcode_i)
            OPC_BIT_JUMP: begin
                cyc_nxt = CYC_BIT_JUMP;
            end
            OPC_BIT_XOR: begin
                cyc_nxt = CYC_BIT_XOR;
            end
            OPC_CALL_DIRECT: begin
                cyc_nxt = CYC_CALL_DIRECT;
            end
            OPC_CALL_PAIR: begin
                cyc_nxt = CYC_CALL_PAIR;
                len_nxt = LEN_TWO;
            end
            OPC_CALL_VECTOR: begin
                cyc_nxt = CYC_CALL_VECTOR;
                len_nxt = LEN_TWO;
            end
            default: begin
                known_op = 1'b0;
            end
        endcase
    end

    // ---------------------------------------------------------------
    // Bit exclusive-OR datapath
    // ---------------------------------------------------------------
    always_comb begin
        xor_word = opa_r;
        if (sel_bit) begin
            xor_bit = rf_rdata_i[bit_idx] ^ opa_r[0];
            // Only bit b of the any-register destination
            xor_word = rf_rdata_i;
            xor_word[bit_idx] = xor_bit;
        end else begin
            xor_bit = opa_r[0] ^ rf_rdata_i[bit_idx];
            // Only bit zero of the working destination
            xor_word[0] = xor_bit;
        end
    end

    assign xor_wr = (state_r == ST_RD2) && (opc_r == OPC_BIT_XOR);

    // ---------------------------------------------------------------
    // Sequencer
    // ---------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= ST_IDLE;
            opc_r <= 8'h00;
            b2_r <= 8'h00;
            b3_r <= 8'h00;
            ret_r <= 16'h0000;
            target_r <= 16'h0000;
            opa_r <= 8'h00;
            cnt_r <= 4'h0;
            taken_r <= 1'b0;
            rf_addr_o <= 8'h00;
            rf_we_o <= 1'b0;
            rf_wdata_o <= 8'h00;
            pm_addr_o <= 16'h0000;
        end else begin
            rf_we_o <= 1'b0;
            if (state_r != ST_IDLE) begin
                cnt_r <= cnt_r - 4'h1;
            end
            case (state_r)
                ST_IDLE: begin
                    if (start && known_op) begin
                        opc_r <= opcode_i;
                        b2_r <= byte2_i;
                        b3_r <= byte3_i;
                        cnt_r <= cyc_nxt - 4'h2;
                        ret_r <= instr_pc_i + len_nxt;
                        taken_r <= 1'b0;
                        case (opcode_i)
                            OPC_BIT_JUMP: begin
                                rf_addr_o <= {WORK_BASE_P, byte2_i[B2_REG_HI:B2_REG_LO]};
                                state_r <= ST_RD1;
                            end
                            OPC_BIT_XOR: begin
                                rf_addr_o <= {WORK_BASE_P, byte2_i[B2_REG_HI:B2_REG_LO]};
                                state_r <= ST_RD1;
                            end
                            OPC_CALL_PAIR: begin
                                rf_addr_o <= byte2_i;
                                state_r <= ST_RD1;
                            end
                            OPC_CALL_VECTOR: begin
                                pm_addr_o <= {8'h00, byte2_i};
                                state_r <= ST_VEC1;
                            end
                            default: begin
                                target_r <= {byte2_i, byte3_i};
                                state_r <= ST_PUSH_LO;
                            end
                        endcase
                    end
                end
                ST_RD1: begin
                    opa_r <= rf_rdata_i;
                    if (opc_r == OPC_BIT_JUMP) begin
                        // Test bit against selector; selector zero inverts
                        taken_r <= (rf_rdata_i[bit_idx] == sel_bit);
                        target_r <= ret_r + {{8{b3_r[7]}}, b3_r};
                        state_r <= ST_WAIT;
                    end else if (opc_r == OPC_BIT_XOR) begin
                        rf_addr_o <= b3_r;
                        state_r <= ST_RD2;
                    end else begin
                        rf_addr_o <= b2_r + 8'h01;
                        state_r <= ST_RD2;
                    end
                end
                ST_RD2: begin
                    if (xor_wr) begin
                        rf_we_o <= 1'b1;
                        rf_wdata_o <= xor_word;
                        rf_addr_o <= sel_bit ? b3_r : work_addr;
                        state_r <= ST_WAIT;
                    end else begin
                        target_r <= {opa_r, rf_rdata_i};
                        state_r <= ST_PUSH_LO;
                    end
                end
                ST_VEC1: begin
                    target_r[15:8] <= pm_rdata_i;
                    pm_addr_o <= pm_addr_o + 16'h0001;
                    state_r <= ST_VEC2;
                end
                ST_VEC2: begin
                    target_r[7:0] <= pm_rdata_i;
                    state_r <= ST_PUSH_LO;
                end
                ST_PUSH_LO: begin
                    state_r <= ST_PUSH_HI;
                end
                ST_PUSH_HI: begin
                    state_r <= ST_WAIT;
                end
                ST_WAIT: begin
                    if (cnt_r == 4'h0) begin
                        state_r <= ST_IDLE;
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Stack pushes and stack pointer
    // ---------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            sp_r <= SP_RESET;
            stk_we_o <= 1'b0;
            stk_addr_o <= 16'h0000;
            stk_wdata_o <= 8'h00;
        end else begin
            stk_we_o <= 1'b0;
            // Decrement, low byte, decrement, high byte
            if (state_r == ST_PUSH_LO) begin
                sp_r <= sp_r - 16'h0001;
                stk_we_o <= 1'b1;
                stk_addr_o <= sp_r - 16'h0001;
                stk_wdata_o <= ret_r[7:0];
            end else if (state_r == ST_PUSH_HI) begin
                sp_r <= sp_r - 16'h0001;
                stk_we_o <= 1'b1;
                stk_addr_o <= sp_r - 16'h0001;
                stk_wdata_o <= ret_r[15:8];
            end else if (wb_wr && wb_adr_i == REG_SP && state_r == ST_IDLE) begin
                // Software may move the stack only while nothing runs
                sp_r[7:0] <= wb_dat_i[7:0];
                if (wb_sel_i[1]) begin
                    sp_r[15:8] <= wb_dat_i[15:8];
                end
            end
        end
    end

    // ---------------------------------------------------------------
    // Completion and program counter
    // ---------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            done_o <= 1'b0;
            pc_load_o <= 1'b0;
            pc_o <= 16'h0000;
            busy_o <= 1'b0;
            last_pc_r <= 16'h0000;
        end else begin
            done_o <= finish;
            pc_load_o <= finish;
            busy_o <= (start && known_op) || ((state_r != ST_IDLE) && !finish);
            if (finish) begin
                // Untaken jump and bit xor fall through past the instruction
                if (opc_r == OPC_BIT_XOR || (opc_r == OPC_BIT_JUMP && !taken_r)) begin
                    pc_o <= ret_r;
                    last_pc_r <= ret_r;
                end else begin
                    pc_o <= target_r;
                    last_pc_r <= target_r;
                end
            end
        end
    end

    // ---------------------------------------------------------------
    // Flags
    // ---------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            flags_r <= FLAGS_RESET;
        end else if (xor_wr) begin
            // Z from result, S cleared, others kept
            flags_r[FLAG_Z] <= ~xor_bit;
            flags_r[FLAG_S] <= 1'b0;
        end else if (wb_wr && wb_adr_i == REG_FLAGS) begin
            // Jumps and calls never reach this register
            flags_r <= wb_dat_i[7:0];
        end
    end

    assign flags_o = flags_r;

    // ---------------------------------------------------------------
    // Control and status
    // ---------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_en_r <= CTRL_RESET;
            illegal_r <= 1'b0;
        end else begin
            if (wb_wr && wb_adr_i == REG_CTRL) begin
                ctrl_en_r <= wb_dat_i[CTRL_EN];
            end
            // A new fault wins over a clear in the same cycle
            if (start && !known_op) begin
                illegal_r <= 1'b1;
            end else if (wb_wr && wb_adr_i == REG_STATUS && wb_dat_i[ST_ILLEGAL]) begin
                illegal_r <= 1'b0;
            end
        end
    end

    // ---------------------------------------------------------------
    // Wishbone slave, one wait state
    // ---------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= wb_req;
            wb_dat_o <= 32'h00000000;
            if (wb_req && !wb_we_i) begin
                case (wb_adr_i)
                    REG_CTRL: wb_dat_o[CTRL_EN] <= ctrl_en_r;
                    REG_FLAGS: wb_dat_o[7:0] <= flags_r;
                    REG_SP: wb_dat_o[15:0] <= sp_r;
                    REG_STATUS: begin
                        wb_dat_o[ST_BUSY] <= busy_o;
                        wb_dat_o[ST_TAKEN] <= taken_r;
                        wb_dat_o[ST_ILLEGAL] <= illegal_r;
                    end
                    REG_LAST_PC: wb_dat_o[15:0] <= last_pc_r;
                    default: wb_dat_o <= 32'h00000000;
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// [testbench/bbxc_exec_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
module bbxc_exec_monitor
    import bbxc_pkg::*;
#(
    parameter logic [3:0] WORK_BASE_P = WORK_BASE
) (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic instr_valid_i,
    input wire logic [7:0] opcode_i,
    input wire logic [7:0] byte2_i,
    input wire logic [7:0] byte3_i,
    input wire logic [15:0] instr_pc_i,
    input wire logic busy_o,
    input wire logic done_o,
    input wire logic pc_load_o,
    input wire logic [15:0] pc_o,
    input wire logic [7:0] rf_addr_o,
    input wire logic rf_we_o,
    input wire logic [7:0] rf_wdata_o,
    input wire logic stk_we_o,
    input wire logic [15:0] stk_addr_o,
    input wire logic [7:0] stk_wdata_o,
    input wire logic [7:0] flags_o
);
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!rst_n_i);
    logic tk;
    logic call;
    // Enable is assumed left at its reset value
    assign tk = instr_valid_i && !busy_o && !done_o;
    assign call = tk && (opcode_i == OPC_CALL_DIRECT || opcode_i == OPC_CALL_PAIR || opcode_i == OPC_CALL_VECTOR);
    logic cd;
    assign cd = call && opcode_i == OPC_CALL_DIRECT;
    // ----
    // Sequences
    // ----
    sequence push_pair;
        stk_we_o ##1 stk_we_o && stk_addr_o == $past(stk_addr_o) - 16'h0001 ##1 !stk_we_o;
    endsequence
    property ret_pushed;
        logic [15:0] r;
        (cd, r = instr_pc_i + LEN_THREE) |-> ##2 stk_wdata_o == r[7:0] ##1 stk_wdata_o == r[15:8];
    endproperty
    property ret_pushed_ind;
        logic [15:0] r;
        (call && !cd, r = instr_pc_i + LEN_TWO) |-> ##4 stk_wdata_o == r[7:0] ##1 stk_wdata_o == r[15:8];
    endproperty
    property xor_dest;
        logic [7:0] a;
        (tk && opcode_i == OPC_BIT_XOR, a = byte2_i[0] ? byte3_i : {WORK_BASE_P, byte2_i[7:4]})
            |-> ##3 rf_we_o && rf_addr_o == a ##1 !rf_we_o;
    endproperty
    property xor_flags;
        logic [2:0] b;
        (tk && opcode_i == OPC_BIT_XOR, b = byte2_i[0] ? byte2_i[3:1] : 3'h0)
            |-> ##3 flags_o[FLAG_Z] == !rf_wdata_o[b] && !flags_o[FLAG_S];
    endproperty
    property jump_target;
        logic [15:0] p;
        logic [15:0] d;
        (tk && opcode_i == OPC_BIT_JUMP, p = instr_pc_i + LEN_THREE, d = {{8{byte3_i[7]}}, byte3_i})
            |-> ##10 pc_load_o && (pc_o == p || pc_o == p + d);
    endproperty
    property call_target;
        logic [15:0] t;
        (tk && opcode_i == OPC_CALL_DIRECT, t = {byte2_i, byte3_i}) |-> ##14 pc_load_o && pc_o == t;
    endproperty
    // ----
    // Assertions
    // ----
    AST_JUMP_LEN: assert property (tk && opcode_i == OPC_BIT_JUMP |-> ##2 !done_o [*8] ##1 done_o)
        else $error("bit jump length wrong");
    AST_XOR_LEN: assert property (tk && opcode_i == OPC_BIT_XOR |-> ##1 !done_o [*5] ##1 done_o)
        else $error("bit xor length wrong");
    AST_CALL_PAIR_LEN: assert property (tk && opcode_i == OPC_CALL_PAIR |-> ##12 done_o)
        else $error("pair call length wrong");
    AST_CALL_LONG_LEN: assert property (call && opcode_i != OPC_CALL_PAIR |-> ##14 done_o)
        else $error("direct or vector call length wrong");
    AST_FLAGS_KEPT: assert property (tk && opcode_i != OPC_BIT_XOR |=> $stable(flags_o) [*8])
        else $error("flags moved during jump or call");
    AST_PUSH_ORDER: assert property (cd |-> ##2 push_pair)
        else $error("stack pushes out of order");
    AST_PUSH_ORDER_IND: assert property (call && !cd |-> ##4 push_pair)
        else $error("indirect pushes out of order");
    AST_RET_ADDR: assert property (ret_pushed)
        else $error("return address wrong");
    AST_RET_ADDR_IND: assert property (ret_pushed_ind)
        else $error("indirect return address wrong");
    AST_XOR_DEST: assert property (xor_dest)
        else $error("bit xor wrote wrong place");
    AST_XOR_FLAGS: assert property (xor_flags)
        else $error("bit xor flags wrong");
    AST_JUMP_TARGET: assert property (jump_target)
        else $error("bit jump target wrong");
    AST_CALL_TARGET: assert property (call_target)
        else $error("direct call target wrong");
endmodule
`default_nettype wire

// [testbench/bbxc_far_side.sv]
`timescale 1ns/1ps
`default_nettype none
module bbxc_far_side (
    input wire logic mclk_i,
    input wire logic [7:0] rf_addr_i,
    output logic [7:0] rf_rdata_o,
    input wire logic rf_we_i,
    input wire logic [7:0] rf_wdata_i,
    input wire logic [15:0] pm_addr_i,
    output logic [7:0] pm_rdata_o,
    input wire logic stk_we_i,
    input wire logic [15:0] stk_addr_i,
    input wire logic [7:0] stk_wdata_i
);
    logic [7:0] rf [256];
    logic [7:0] stk [256];
    // Same-cycle reads, as the core expects
    assign rf_rdata_o = rf[rf_addr_i];
    // Address-dependent pattern so a wrong byte order shows
    assign pm_rdata_o = pm_addr_i[7:0] ^ 8'h75;
    // Plain always: the bench also preloads these arrays
    always @(posedge mclk_i) begin
        if (rf_we_i) begin
            rf[rf_addr_i] <= rf_wdata_i;
        end
        if (stk_we_i) begin
            stk[stk_addr_i[7:0]] <= stk_wdata_i;
        end
    end
endmodule
`default_nettype wire

// [testbench/bit_branch_xor_call_exec_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module bit_branch_xor_call_exec_bench;
    import bbxc_pkg::*;
    logic mclk_i, rst_n_i, instr_valid_i, wb_cyc_i, wb_stb_i, wb_we_i;
    logic busy_o, done_o, pc_load_o, rf_we_o, stk_we_o, wb_ack_o;
    logic [7:0] opcode_i, byte2_i, byte3_i, wb_adr_i, rf_addr_o, rf_rdata_i, rf_wdata_o;
    logic [7:0] pm_rdata_i, stk_wdata_o, flags_o;
    logic [15:0] instr_pc_i, pc_o, pm_addr_o, stk_addr_o, got_pc;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, rd;
    int n_errors, cmp_count, i;
    logic [7:0] jb2 [4] = '{8'h13, 8'h17, 8'h16, 8'h12};
    logic [7:0] jb3 [4] = '{8'h7F, 8'h7F, 8'h80, 8'h80};
    logic [15:0] jpc [4] = '{16'h1082, 16'h1003, 16'h0F83, 16'h1003};
    logic [7:0] cop [3] = '{OPC_CALL_DIRECT, OPC_CALL_PAIR, OPC_CALL_VECTOR};
    logic [7:0] cb2 [3] = '{8'h35, 8'hC0, 8'h40};
    int cn [3] = '{14, 12, 14};
    logic [15:0] ct [3] = '{16'h3521, 16'h3521, 16'h3534};
    logic [15:0] cr [3] = '{16'h1A4A, 16'h1A49, 16'h1A49};
    bbxc_exec uut (
        .mclk_i, .rst_n_i, .instr_valid_i, .opcode_i, .byte2_i, .byte3_i, .instr_pc_i,
        .busy_o, .done_o, .pc_load_o, .pc_o, .rf_addr_o, .rf_rdata_i, .rf_we_o, .rf_wdata_o,
        .pm_addr_o, .pm_rdata_i, .stk_we_o, .stk_addr_o, .stk_wdata_o, .flags_o,
        .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o
    );
    bbxc_far_side far (
        .mclk_i(mclk_i), .rf_addr_i(rf_addr_o), .rf_rdata_o(rf_rdata_i), .rf_we_i(rf_we_o),
        .rf_wdata_i(rf_wdata_o), .pm_addr_i(pm_addr_o), .pm_rdata_o(pm_rdata_i),
        .stk_we_i(stk_we_o), .stk_addr_i(stk_addr_o), .stk_wdata_i(stk_wdata_o)
    );
    // ----
    // Tasks
    // ----
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        int k;
        @(posedge mclk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        for (k = 0; k < 16; k++) begin
            @(posedge mclk_i);
            if (wb_ack_o === 1'b1) break;
        end
        chk("bus ack", 1, k < 16);
        if (k == 16) final_report();
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    // Offer one instruction, then count edges up to the done pulse
    task automatic run(input logic [7:0] op, b2, b3, input logic [15:0] pc, input int n);
        int k;
        @(posedge mclk_i);
        instr_valid_i <= 1'b1;
        opcode_i <= op;
        byte2_i <= b2;
        byte3_i <= b3;
        instr_pc_i <= pc;
        @(posedge mclk_i);
        instr_valid_i <= 1'b0;
        for (k = 1; k < 40; k++) begin
            @(posedge mclk_i);
            if (k == 1) chk("busy", 1, busy_o);
            if (done_o === 1'b1) break;
        end
        chk("cycles", n, k);
        if (k == 40) final_report();
        got_pc = pc_o;
    endtask
    initial begin
        mclk_i = 1'b0;
        forever #12.5 mclk_i = ~mclk_i;
    end
    // ----
    // Tests
    // ----
    initial begin
        {rst_n_i, instr_valid_i, wb_cyc_i, wb_stb_i, wb_we_i} = 5'h00;
        {opcode_i, byte2_i, byte3_i, wb_adr_i, instr_pc_i} = 48'h0;
        wb_sel_i = 4'hF;
        wb_dat_i = 32'h0;
        n_errors = 0;
        cmp_count = 0;
        repeat (8) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        repeat (3) @(posedge mclk_i);
        // All flags set, so any disturbance shows
        wb_xfer(1'b1, REG_FLAGS, 32'h000000FF);
        far.rf[8'hC1] = 8'h07;
        for (i = 0; i < 4; i++) begin
            run(OPC_BIT_JUMP, jb2[i], jb3[i], 16'h1000, 10);
            chk("jump pc", jpc[i], got_pc);
            chk("flags", 8'hFF, flags_o);
        end
        $display("bit jump test done");
        far.rf[8'h01] = 8'h03;
        run(OPC_BIT_XOR, 8'h12, 8'h01, 16'h2000, 6);
        chk("xor pc", 16'h2003, got_pc);
        chk("xor dst", 8'h06, far.rf[8'hC1]);
        chk("xor src", 8'h03, far.rf[8'h01]);
        chk("flags", 8'hDF, flags_o);
        far.rf[8'hC1] = 8'h07;
        run(OPC_BIT_XOR, 8'h15, 8'h01, 16'h2000, 6);
        chk("xor dst", 8'h07, far.rf[8'h01]);
        chk("xor src", 8'h07, far.rf[8'hC1]);
        chk("flags", 8'h9F, flags_o);
        $display("bit xor test done");
        far.rf[8'hC0] = 8'h35;
        far.rf[8'hC1] = 8'h21;
        for (i = 0; i < 3; i++) begin
            far.stk[0] = 8'hEE;
            far.stk[1] = 8'hEE;
            wb_xfer(1'b1, REG_SP, 32'h00000002);
            run(cop[i], cb2[i], 8'h21, 16'h1A47, cn[i]);
            chk("call pc", ct[i], got_pc);
            chk("ret low", cr[i][7:0], far.stk[1]);
            chk("ret high", cr[i][15:8], far.stk[0]);
            chk("flags", 8'h9F, flags_o);
            wb_xfer(1'b0, REG_SP, 32'h0);
            chk("sp", 32'h0, rd);
        end
        $display("call test done");
        wb_xfer(1'b1, 8'h20, 32'h000000AA);
        wb_xfer(1'b0, 8'h20, 32'h0);
        chk("unmapped", 32'h0, rd);
        wb_xfer(1'b0, REG_FLAGS, 32'h0);
        chk("flags reg", 32'h0000009F, rd);
        opcode_i <= 8'hFF;
        instr_valid_i <= 1'b1;
        @(posedge mclk_i);
        instr_valid_i <= 1'b0;
        wb_xfer(1'b0, REG_STATUS, 32'h0);
        chk("status", 32'h4, rd);
        $display("register test done");
        final_report();
    end
endmodule
bind bbxc_exec bbxc_exec_monitor #(.WORK_BASE_P(WORK_BASE_P)) mon (
    .mclk_i, .rst_n_i, .instr_valid_i, .opcode_i, .byte2_i, .byte3_i, .instr_pc_i,
    .busy_o, .done_o, .pc_load_o, .pc_o, .rf_addr_o, .rf_we_o, .rf_wdata_o,
    .stk_we_o, .stk_addr_o, .stk_wdata_o, .flags_o
);
`default_nettype wire
